// [inc/abs_reader_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef ABS_READER_REGS_SVH
`define ABS_READER_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_INFO 8'h0C
`define REG_RESULT 8'h10
`define REG_TIMEOUT 8'h14
`define REG_CHECK 8'h18
`define REG_CHAN_BASE 4'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_ACT_BIT 0
`define CTRL_CH_LSB 1
`define CTRL_CH_MSB 2
`define CTRL_CLEAR_BIT 3
`define CTRL_DEST_BIT 4
`define CTRL_WIDTH 5
`define STAT_DONE_BIT 0
`define STAT_ABN_BIT 1
`define STAT_ABORT_BIT 2
`define STAT_WIDTH 3

// ----------------------------------------------------------------
// Reset values and sequence figures
// ----------------------------------------------------------------
`define CTRL_RST 5'h00
`define STAT_RST 3'h0
`define MASK_RST 3'h0
`define POS_RST 16'h0000
`define LAST_STEP 5'h12
`define SHIFT_BITS 38

// ----------------------------------------------------------------
// Timing: clock rate, settle time, default step timeout
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define SETTLE_NS 16
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_US 1000
`define TIMEOUT_CYC ((`TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

`endif

// [inc/abs_reader_pkg.sv]
// Types shared by the absolute position reader
package abs_reader_pkg;

	// Handshake sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETTLE = 3'b001,
		ST_REQ = 3'b010,
		ST_REL = 3'b011,
		ST_DONE = 3'b100,
		ST_FAULT = 3'b101
	} seq_state_t;

	typedef logic [1:0] chan_sel_t;

endpackage

// [rtl/pin_sync.sv]
// Two-flop synchroniser for the amplifier and strap pins
`timescale 1ns/1ns

module pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [3:0] pins_in,
	output logic [3:0] pins_out
);

	logic [3:0] meta_q;
	logic [3:0] stable_q;

	// ------------------------------------------------------------
	// Synchroniser flops
	// ------------------------------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 4'h0;
			stable_q <= 4'h0;
		end
		else if (ce)
		begin
			meta_q <= pins_in;
			stable_q <= meta_q;
		end
	end

	assign pins_out = stable_q;

endmodule

// [rtl/abs_shift.sv]
// Collector that packs two-bit handshake steps into data and check
`timescale 1ns/1ns

module abs_shift (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic clr,
	input wire logic load,
	input wire logic [4:0] step,
	input wire logic [1:0] bits,
	output logic [31:0] position,
	output logic [5:0] check
);

	logic [37:0] data_q;
	wire [5:0] slot = {step, 1'b0};

	// ------------------------------------------------------------
	// Capture store
	// ------------------------------------------------------------
	// Each step lands at its own slot, lowest pair first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_q <= 38'h0;
		else if (ce && clr)
			data_q <= 38'h0;
		else if (ce && load)
			data_q[slot +: 2] <= bits;
	end

	assign position = data_q[31:0];
	assign check = data_q[37:32];

endmodule

// [rtl/abs_position_reader.sv]
// APB-controlled absolute position reader for a servo amplifier
`timescale 1ns/1ns
`include "abs_reader_regs.svh"

module abs_position_reader #(
	parameter int unsigned TIMEOUT_DEFAULT = `TIMEOUT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic abs_bit0_in,
	input wire logic abs_bit1_in,
	input wire logic send_ready_in,
	input wire logic dual_adapter_in,
	output logic servo_on_out,
	output logic transfer_mode_out,
	output logic data_request_out,
	output logic clear_out,
	output logic irq
);
	import abs_reader_pkg::*;

	// ------------------------------------------------------------
	// Address decode helper
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [31:0] a,
		input logic [7:0] off);
		reg_hit = (a[7:0] == off);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [3:0] pins_s;
	wire bit0_s = pins_s[0];
	wire bit1_s = pins_s[1];
	wire ready_s = pins_s[2];
	wire adapters_s = pins_s[3];

	// Every amplifier pin passes two flops before use
	pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pins_in({dual_adapter_in, send_ready_in, abs_bit1_in,
			abs_bit0_in}),
		.pins_out(pins_s)
	);

	// ------------------------------------------------------------
	// Registers and bus decode
	// ------------------------------------------------------------
	logic [4:0] ctrl_q;
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q;
	logic [31:0] timeout_q;
	logic [31:0] result_q;
	logic [5:0] check_q;
	logic [31:0] prdata_q;
	logic [15:0] pos_lo_q [4];
	logic [15:0] pos_hi_q [4];
	seq_state_t state_q, state_d;
	logic [4:0] step_q;
	logic [31:0] wait_q;
	logic done_flag_q;
	logic abn_flag_q;

	wire setup = psel && !penable;
	wire wr_en = psel && penable && pwrite;
	wire hit_ctrl = reg_hit(paddr, `REG_CTRL);
	wire hit_stat = reg_hit(paddr, `REG_STATUS);
	wire hit_mask = reg_hit(paddr, `REG_MASK);
	wire hit_info = reg_hit(paddr, `REG_INFO);
	wire hit_result = reg_hit(paddr, `REG_RESULT);
	wire hit_timeout = reg_hit(paddr, `REG_TIMEOUT);
	wire hit_check = reg_hit(paddr, `REG_CHECK);
	wire hit_chan = (paddr[7:4] == `REG_CHAN_BASE) && (paddr[1:0] == 2'b00);
	wire [1:0] bus_ch = paddr[3:2];
	wire addr_ok = hit_ctrl || hit_stat || hit_mask || hit_info ||
		hit_result || hit_timeout || hit_check || hit_chan;

	wire act = ctrl_q[`CTRL_ACT_BIT];
	wire chan_sel_t sel_ch = ctrl_q[`CTRL_CH_MSB:`CTRL_CH_LSB];
	wire to_result = ctrl_q[`CTRL_DEST_BIT];

	// Zero-wait slave: the access phase always completes at once
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_q;

	// ------------------------------------------------------------
	// Handshake sequencer
	// ------------------------------------------------------------
	logic [31:0] shift_pos;
	logic [5:0] shift_chk;
	wire busy = (state_q == ST_SETTLE) || (state_q == ST_REQ) ||
		(state_q == ST_REL);
	wire start = (state_q == ST_IDLE) && act;
	wire abort = busy && !act;
	wire take_bits = (state_q == ST_REQ) && ready_s && act;
	wire last_step = (step_q == `LAST_STEP);
	wire step_end = (state_q == ST_REL) && !ready_s && act;
	wire finish = step_end && last_step;
	wire settled = (wait_q >= (`SETTLE_CYC - 1));
	wire timed_out = (state_q == ST_REQ || state_q == ST_REL) &&
		(timeout_q != 32'h0) && (wait_q >= timeout_q - 32'h1);
	// Fourth channel only answers when both adapters are fitted, except on reads steered into the result register
	wire ch_present = (sel_ch != 2'h3) || adapters_s;

	// Next state; withdrawal of activation wins over any progress
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (act)
					state_d = ST_SETTLE;
			ST_SETTLE:
				if (!act)
					state_d = ST_IDLE;
				else if (settled)
					state_d = ST_REQ;
			ST_REQ:
				if (!act)
					state_d = ST_IDLE;
				else if (timed_out)
					state_d = ST_FAULT;
				else if (ready_s)
					state_d = ST_REL;
			ST_REL:
				if (!act)
					state_d = ST_IDLE;
				else if (timed_out)
					state_d = ST_FAULT;
				else if (!ready_s)
					state_d = last_step ? ST_DONE : ST_REQ;
			ST_DONE:
				if (!act)
					state_d = ST_IDLE;
			ST_FAULT:
				if (!act)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// State, step count and per-step wait counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_IDLE;
			step_q <= 5'h00;
			wait_q <= 32'h0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			if (start)
				step_q <= 5'h00;
			else if (step_end && !last_step)
				step_q <= step_q + 5'h01;
			if (state_d != state_q || take_bits)
				wait_q <= 32'h0;
			else if (wait_q != 32'hFFFF_FFFF)
				wait_q <= wait_q + 32'h1;
		end
	end

	// Two bits arrive together on every step
	abs_shift u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clr(start),
		.load(take_bits),
		.step(step_q),
		.bits({bit1_s, bit0_s}),
		.position(shift_pos),
		.check(shift_chk)
	);

	// Handshake pin drive decoded from the state flops
	assign servo_on_out = (state_q != ST_IDLE) && (state_q != ST_FAULT);
	assign transfer_mode_out = busy;
	assign data_request_out = (state_q == ST_REQ);
	// Clear is a plain software-driven output, taken straight from the control clear bit
	assign clear_out = ctrl_q[`CTRL_CLEAR_BIT];

	// ------------------------------------------------------------
	// Completion flags, result and check capture
	// ------------------------------------------------------------
	// Levels: cleared on a new start, set at the end of the read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_flag_q <= 1'b0;
			abn_flag_q <= 1'b0;
			result_q <= 32'h0;
			check_q <= 6'h00;
		end
		else if (ce)
		begin
			if (start)
				done_flag_q <= 1'b0;
			else if (finish)
				done_flag_q <= 1'b1;
			if (start)
				abn_flag_q <= 1'b0;
			else if (timed_out || (finish && !ch_present && !to_result))
				abn_flag_q <= 1'b1;
			if (finish && to_result)
				result_q <= shift_pos;
			if (finish)
				check_q <= shift_chk;
		end
	end

	// Channel current value registers, split into two words
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_chan
			wire eng_wr = finish && !to_result && ch_present &&
				(sel_ch == ch);
			wire bus_wr = wr_en && hit_chan && (bus_ch == ch);
			// Sequencer result wins over a same-cycle bus write
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pos_lo_q[ch] <= `POS_RST;
					pos_hi_q[ch] <= `POS_RST;
				end
				else if (ce && eng_wr)
				begin
					pos_lo_q[ch] <= shift_pos[15:0];
					pos_hi_q[ch] <= shift_pos[31:16];
				end
				else if (ce && bus_wr)
				begin
					pos_lo_q[ch] <= pwdata[15:0];
					pos_hi_q[ch] <= pwdata[31:16];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Control, status, mask, timeout
	// ------------------------------------------------------------
	wire [2:0] events;
	assign events[`STAT_DONE_BIT] = finish;
	assign events[`STAT_ABN_BIT] = timed_out;
	assign events[`STAT_ABORT_BIT] = abort;
	wire [2:0] w1c = (wr_en && hit_stat) ? pwdata[2:0] : 3'h0;

	// Sticky status: a new event beats a same-cycle clear
	always_comb
	begin
		stat_d = (stat_q & ~w1c) | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `CTRL_RST;
			stat_q <= `STAT_RST;
			mask_q <= `MASK_RST;
			timeout_q <= TIMEOUT_DEFAULT;
		end
		else if (ce)
		begin
			stat_q <= stat_d;
			if (wr_en && hit_ctrl)
				ctrl_q <= pwdata[4:0];
			if (wr_en && hit_mask)
				mask_q <= pwdata[2:0];
			if (wr_en && hit_timeout)
				timeout_q <= pwdata;
		end
	end

	assign irq = |(stat_q & mask_q);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire [31:0] info_word = {16'h0, 3'h0, step_q, adapters_s, state_q,
		1'b0, busy, abn_flag_q, done_flag_q};
	wire [31:0] chan_word = {pos_hi_q[bus_ch], pos_lo_q[bus_ch]};
	wire [31:0] rd_word =
		hit_ctrl ? {27'h0, ctrl_q} :
		hit_stat ? {29'h0, stat_q} :
		hit_mask ? {29'h0, mask_q} :
		hit_info ? info_word :
		hit_result ? result_q :
		hit_timeout ? timeout_q :
		hit_check ? {26'h0, check_q} :
		hit_chan ? chan_word : 32'h0;

	// Read data is captured in setup so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0;
		else if (ce && setup && !pwrite)
			prdata_q <= rd_word;
	end

endmodule

// [bench/abs_reader_assertions.sv]
// Assertions on the reader's amplifier and bus pins
`timescale 1ns/1ns

module abs_reader_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic send_ready_in,
	input wire logic servo_on_out,
	input wire logic transfer_mode_out,
	input wire logic data_request_out
);
	// ----
	// Handshake order and bus error
	// ----
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_mode_servo;
		transfer_mode_out |-> servo_on_out;
	endproperty
	a_mode_servo: assert property (p_mode_servo)
		else $error("mode without servo-on");
	property p_rise_pair;
		$rose(servo_on_out) |-> transfer_mode_out && !data_request_out;
	endproperty
	a_rise_pair: assert property (p_rise_pair)
		else $error("servo-on rose alone");
	property p_req_mode;
		data_request_out |-> servo_on_out && transfer_mode_out;
	endproperty
	a_req_mode: assert property (p_req_mode)
		else $error("request outside transfer mode");
	// Settle is two cycles before the first request, unless withdrawn
	property p_settle;
		$rose(transfer_mode_out) |-> !data_request_out [*2] ##1
			(data_request_out || !transfer_mode_out);
	endproperty
	a_settle: assert property (p_settle)
		else $error("first request not after settle");
	property p_req_start;
		$rose(data_request_out) |-> !$past(send_ready_in) && !send_ready_in;
	endproperty
	a_req_start: assert property (p_req_start)
		else $error("request while ready high");
	property p_req_release;
		$fell(data_request_out) && transfer_mode_out |-> $past(send_ready_in);
	endproperty
	a_req_release: assert property (p_req_release)
		else $error("request dropped without ready");
	property p_mode_fall;
		$fell(transfer_mode_out) |-> !data_request_out;
	endproperty
	a_mode_fall: assert property (p_mode_fall)
		else $error("request left high");
	property p_slverr;
		pslverr |-> psel && penable;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("error outside access");

	cover property ($rose(data_request_out));
	cover property ($fell(transfer_mode_out) && servo_on_out);
	cover property (pslverr);
endmodule

bind abs_position_reader abs_reader_assertions u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
	.send_ready_in(send_ready_in), .servo_on_out(servo_on_out),
	.transfer_mode_out(transfer_mode_out),
	.data_request_out(data_request_out));

// [bench/servo_amp_model.sv]
// Behavioural servo amplifier answering the two-bit handshake
`timescale 1ns/1ns

module servo_amp_model (
	input wire logic pclk,
	input wire logic mode,
	input wire logic req,
	input wire logic stall,
	input wire logic [3:0] lag,
	input wire logic [37:0] frame,
	output logic bit0 = 1'b0,
	output logic bit1 = 1'b0,
	output logic ready = 1'b0
);
	int step = 0;
	int cnt = 0;

	// Data lead ready by lag+1 cycles so they have crossed the synchroniser before ready does
	always @(posedge pclk)
	begin
		if (!mode)
		begin
			step <= 0;
			cnt <= 0;
			ready <= 1'b0;
		end
		else if (req && !ready && !stall)
		begin
			cnt <= cnt + 1;
			if (cnt == 0)
				{bit1, bit0} <= frame[2 * step +: 2];
			if (cnt > lag)
				ready <= 1'b1;
		end
		else if (!req && ready)
		begin
			ready <= 1'b0;
			step <= step + 1;
			cnt <= 0;
			{bit1, bit0} <= ~{bit1, bit0}; // Released lines do not hold
		end
	end
endmodule

// [bench/tb.sv]
// Self-checking bench for the absolute position reader
`timescale 1ns/1ns

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, keep;
	logic b0, b1, rdy, adp, servo_on, mode, req, clr, irq, stall;
	logic [3:0] lag;
	logic [37:0] frame;
	logic [31:0] exp_q[$], msk_q[$];
	logic err_q[$];
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int seed = 32'h3c9d;

	// Short step timeout keeps the stall cases quick
	abs_position_reader #(.TIMEOUT_DEFAULT(64)) dut (.pclk(pclk),
		.presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .abs_bit0_in(b0),
		.abs_bit1_in(b1), .send_ready_in(rdy), .dual_adapter_in(adp),
		.servo_on_out(servo_on), .transfer_mode_out(mode),
		.data_request_out(req), .clear_out(clr), .irq(irq));
	servo_amp_model amp (.pclk(pclk), .mode(mode), .req(req),
		.stall(stall), .lag(lag), .frame(frame), .bit0(b0), .bit1(b1),
		.ready(rdy));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task close_out;
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A hang counts as a mismatch
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_count++;
			close_out();
		end
	end

	// Read answers are compared against the oldest note
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
		begin
			check(prdata & msk_q.pop_front(), exp_q.pop_front());
			check(32'(pslverr), 32'(err_q.pop_front()));
		end

	// ----
	// Bus master
	// ----
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF, input logic x = 1'b0);
		exp_q.push_back(e);
		msk_q.push_back(m);
		err_q.push_back(x);
		apb(a, 1'b0, 32'h0);
	endtask

	// Start a read and wait for the interrupt; a hang hits the ceiling
	task run(input logic [1:0] ch, input logic [3:0] l,
		input logic dst = 1'b0);
		frame <= 38'({$random(seed), $random(seed)});
		lag <= l;
		wr(8'h00, {27'h0, dst, 1'b0, ch, 1'b1});
		while (!irq)
			@(negedge pclk);
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{adp, stall, lag, frame} = {1'b1, 1'b0, 4'h0, 38'h0};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h14, 32'h40);
		rd(8'h30, 32'h0, 32'hFFFFFFFF, 1'b1);
		for (int c = 0; c < 4; c++)
			rd(8'(8'h20 + 4 * c), 32'h0);
		wr(8'h08, 32'h7);
		wr(8'h00, 32'h8);
		@(negedge pclk);
		check(32'(clr), 32'h1);
		// Full reads into every channel, quick and slow amplifier
		for (int c = 0; c < 4; c++)
		begin
			run(2'(c), 4'(c * 5));
			check(32'({irq, servo_on, mode}), 32'h6);
			rd(8'(8'h20 + 4 * c), frame[31:0]);
			rd(8'h18, {26'h0, frame[37:32]});
			rd(8'h04, 32'h1);
			rd(8'h0C, 32'h1, 32'h1);
			wr(8'h04, 32'h1);
			wr(8'h00, 32'h0);
			repeat (2) @(negedge pclk);
			check(32'({irq, servo_on}), 32'h0);
		end
		// Channel three without both adapters keeps its old value
		keep = frame[31:0];
		@(posedge pclk);
		adp <= 1'b0;
		run(2'd3, 4'h2);
		rd(8'h0C, 32'h2, 32'h2);
		rd(8'h2C, keep);
		wr(8'h00, 32'h0);
		// A channel-one read steered into the result register
		wr(8'h04, 32'h7);
		run(2'd1, 4'h1, 1'b1);
		rd(8'h10, frame[31:0]);
		rd(8'h04, 32'h1);
		wr(8'h00, 32'h0);
		// Withdrawal in mid-read, then an amplifier that never answers
		@(posedge pclk);
		adp <= 1'b1;
		stall <= 1'b1;
		wr(8'h04, 32'h7);
		wr(8'h00, 32'h1);
		repeat (20) @(negedge pclk);
		check(32'({servo_on, mode, req}), 32'h7);
		wr(8'h00, 32'h0);
		repeat (2) @(negedge pclk);
		check(32'(servo_on), 32'h0);
		rd(8'h04, 32'h4);
		wr(8'h04, 32'h7);
		wr(8'h00, 32'h1);
		repeat (100) @(negedge pclk);
		check(32'({servo_on, req}), 32'h0);
		rd(8'h04, 32'h2);
		rd(8'h0C, 32'h2, 32'h2);
		wr(8'h00, 32'h0);
		close_out();
	end
endmodule
